// >>> status_one_regs.vh
`ifndef STATUS_ONE_REGS_VH
`define STATUS_ONE_REGS_VH
// status register one bit positions
`define SR1_LOCK_BIT      7
`define SR1_TB_BIT        6
`define SR1_BP_HI         5
`define SR1_BP_LO         2
`define SR1_WEL_BIT       1
`define SR1_BUSY_BIT      0
// configuration mode enable bits
`define CR2_QPI_BIT       3
`define CR1_QIO_BIT       1
// opcodes
`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_ENABLE_V 8'h50
`define OP_WRITE_DISABLE  8'h04
`define OP_WRITE_REGS     8'h01
`define OP_WRITE_ANY      8'h71
`define OP_READ_ANY       8'h65
`define OP_READ_SR1       8'h05
`define OP_READ_SR2       8'h07
`define OP_READ_CR1       8'h35
`define OP_READ_CR2       8'h15
`define OP_READ_CR3       8'h33
`define OP_CLEAR_STATUS   8'h30
`define OP_SUSPEND        8'h75
`define OP_RESET_ENABLE   8'h66
`define OP_RESET          8'h99
// operation kinds reported by the array engine
`define OPK_NONE          3'h0
`define OPK_PROG          3'h1
`define OPK_ERASE         3'h2
`define OPK_REG_NV        3'h3
`define OPK_OTHER         3'h4
// reset values
`define SR1_RESET         8'h00
`define BYTE_ZERO         8'h00
`endif

// >>> status_protect_enable_busy_logic.v
`include "status_one_regs.vh"
`default_nettype none
// Behaviour
// - lock bit set and protect pin low blocks status, config, latency writes.
// - lock bit clear or protect pin high allows those register writes.
// - protect pin never affects writes to any other register.
// - volatile lock bit follows changes of its nonvolatile default.
// - quad command or quad data mode forces internal protect level high.
// - top/bottom bit chooses protection anchor: 0 top, 1 bottom.
// - volatile top/bottom bit follows changes of its nonvolatile default.
// - four block protect bits select array area barred from program/erase.
// - program, register write or erase starts only with enable latch set.
// - write enable sets latch; write disable clears it.
// - only enable, volatile enable, disable and clear status commands change latch.
// - latch clears when an embedded operation (program, erase) succeeds.
// - any reset loads the latch from its factory default bit.
// - register write commands leave latch and busy flag unchanged.
// - read status one command returns this register.
// - while busy, only reads, suspend, clear status and reset accepted.
// - suspend accepted only during array program or erase.
// - error bit keeps busy set until clear status or a reset arrives.
// - busy reads 1 during any operation, 0 idle, never writable.
// - resets reload volatile copies; nonvolatile writes refresh them.
module status_protect_enable_busy_logic (
  // clock and reset
  input  wire       i_core_clk,
  input  wire       i_rstn,
  // external pins (asynchronous)
  input  wire       i_write_protect_n,
  // decoded command from serial front end
  input  wire       i_cmd_valid,
  input  wire [7:0] i_cmd_opcode,
  input  wire [7:0] i_wr_data,
  input  wire       i_wr_targets_prot,
  input  wire       i_wr_nv,
  input  wire       i_soft_reset_done,
  // nonvolatile default copy of status one
  input  wire [7:0] i_status_one_nonvolatile,
  input  wire       i_nv_update,
  // volatile configuration mode bits
  input  wire [7:0] i_config_one_volatile,
  input  wire [7:0] i_config_two_volatile,
  // embedded operation engine
  input  wire       i_op_start_req,
  input  wire [2:0] i_op_kind,
  input  wire       i_op_done,
  input  wire       i_op_error,
  // status and control outputs
  output reg  [7:0] o_status_one_volatile,
  output reg  [7:0] o_read_data,
  output reg        o_read_valid,
  output reg        o_cmd_accept,
  output reg        o_cmd_ignored,
  output reg        o_op_start,
  output reg        o_reg_write,
  output reg        o_suspend,
  output reg        o_soft_reset,
  output reg        o_hw_protected
);

  // hazards for whoever touches this block:
  // - the protect pin is slow and asynchronous, so it is synced first
  // - quad modes borrow the pin as a data line, so it reads high then
  // - a command is judged once, in the cycle its opcode is presented
  // - refused commands raise ignored only, never accept as well
  // - the busy view joins a running operation and a held failure
  // - completion and a new enable in one cycle: the enable is refused, busy still set
  // - the status output lags the internal copy by one cycle
  // - the block protect field is only stored here; the address
  //   compare against it lives in the array guard
  // - a register write to the nonvolatile copy comes back through
  //   the update strobe, never through the write path here

  // pin synchroniser, first stage read only by the second
  reg       wp_meta;
  reg       wp_sync;

  // internal state of the volatile status copy
  reg       lock_bit;
  reg       tb_sel;
  reg [3:0] bp_field;
  reg       write_enable_latch;
  // operation tracking
  reg       busy_op;     // embedded operation running
  reg       err_hold;    // failed operation waits for clear status
  reg [2:0] cur_kind;    // kind of the running operation
  // reset sequencing
  reg       reset_armed; // reset enable seen just before
  reg       load_pend;   // defaults still to be loaded


  // decode helpers
  wire       busy_flag;
  wire       wp_internal;
  wire       hw_prot;
  wire       is_read_cmd;
  wire       is_busy_ok;
  wire       array_op;
  wire       allow;
  wire       op_is_wen;
  wire       op_is_wdis;
  wire       op_is_clr;
  wire       op_is_wrreg;
  wire       wr_blocked;
  wire       suspend_ok;
  wire       op_is_susp;
  wire [7:0] sr1_now;


  // two-flop sync of write protect pin
  // resets low, so the block starts out protected until the pin
  // has been seen; this errs on the safe side after power-up
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
    end else begin
      wp_meta <= i_write_protect_n;
      wp_sync <= wp_meta;
    end
  end


  // quad modes reuse the pin as data, forcing it high
  // mode bits come from logic on this clock, so no sync there
  assign wp_internal = wp_sync |
                       i_config_two_volatile[`CR2_QPI_BIT] |
                       i_config_one_volatile[`CR1_QIO_BIT];
  assign hw_prot     = lock_bit & ~wp_internal;


  // busy also covers a failed operation until clear status
  assign busy_flag = busy_op | err_hold;


  // opcode classes
  // every opcode class is a plain compare against the opcode of this cycle;
  // array_op compares the kind of the running operation, and the decision
  // also uses busy, the latch and the reset enable flag; unknown opcodes fall through to the start request, a no-op when it is low
  assign op_is_wen   = (i_cmd_opcode == `OP_WRITE_ENABLE) |
                       (i_cmd_opcode == `OP_WRITE_ENABLE_V);
  assign op_is_wdis  = (i_cmd_opcode == `OP_WRITE_DISABLE);
  assign op_is_clr   = (i_cmd_opcode == `OP_CLEAR_STATUS);
  assign op_is_wrreg = (i_cmd_opcode == `OP_WRITE_REGS) |
                       (i_cmd_opcode == `OP_WRITE_ANY);
  assign is_read_cmd = (i_cmd_opcode == `OP_READ_SR1) |
                       (i_cmd_opcode == `OP_READ_SR2) |
                       (i_cmd_opcode == `OP_READ_ANY) |
                       (i_cmd_opcode == `OP_READ_CR1) |
                       (i_cmd_opcode == `OP_READ_CR2) |
                       (i_cmd_opcode == `OP_READ_CR3);
  assign array_op    = (cur_kind == `OPK_PROG) |
                       (cur_kind == `OPK_ERASE);
  assign op_is_susp  = (i_cmd_opcode == `OP_SUSPEND);
  // suspend only while an array program or erase runs
  assign suspend_ok  = op_is_susp & busy_op &
                       array_op & ~err_hold;

  // accepted set while busy
  assign is_busy_ok  = is_read_cmd | op_is_clr | suspend_ok |
                       (i_cmd_opcode == `OP_RESET_ENABLE) |
                       (i_cmd_opcode == `OP_RESET);
  // a suspend with nothing to suspend is refused even when idle
  assign allow       = (~busy_flag | is_busy_ok) &
                       ~(op_is_susp & ~suspend_ok);

  // protection only covers the protected register set
  // other register writes never look at the pin
  assign wr_blocked  = op_is_wrreg & i_wr_targets_prot & hw_prot;


  // status one as seen from inside, bit order as read back
  assign sr1_now = {lock_bit, tb_sel, bp_field, write_enable_latch, busy_flag};


  // register state, latch, busy and command filtering
  // priority inside one cycle:
  //   1. reload from defaults after any reset
  //   2. nonvolatile change, then operation completion
  //   3. the command, whose writes come last and so win
  // the pulses default low every cycle and rise for one cycle only
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_bit      <= 1'b0;
      tb_sel        <= 1'b0;
      bp_field      <= 4'h0;
      write_enable_latch           <= 1'b0;
      busy_op       <= 1'b0;
      err_hold      <= 1'b0;
      cur_kind      <= `OPK_NONE;
      reset_armed   <= 1'b0;
      load_pend     <= 1'b1;
      o_read_data   <= `BYTE_ZERO;
      o_read_valid  <= 1'b0;
      o_cmd_accept  <= 1'b0;
      o_cmd_ignored <= 1'b0;
      o_op_start    <= 1'b0;
      o_reg_write   <= 1'b0;
      o_suspend     <= 1'b0;
      o_soft_reset  <= 1'b0;
    end else begin
      o_read_valid  <= 1'b0;
      o_cmd_accept  <= 1'b0;
      o_cmd_ignored <= 1'b0;
      o_op_start    <= 1'b0;
      o_reg_write   <= 1'b0;
      o_suspend     <= 1'b0;
      o_soft_reset  <= 1'b0;
      if (load_pend | i_soft_reset_done) begin
        // power-on, hardware or software reset: load from defaults
        load_pend   <= 1'b0;
        lock_bit    <= i_status_one_nonvolatile[`SR1_LOCK_BIT];
        tb_sel      <= i_status_one_nonvolatile[`SR1_TB_BIT];
        bp_field    <= i_status_one_nonvolatile[`SR1_BP_HI:`SR1_BP_LO];
        write_enable_latch         <= i_status_one_nonvolatile[`SR1_WEL_BIT];
        busy_op     <= i_status_one_nonvolatile[`SR1_BUSY_BIT];
        // a pending failure is dropped by any reset
        err_hold    <= 1'b0;
        cur_kind    <= `OPK_NONE;
        reset_armed <= 1'b0;
      end else begin
        // nonvolatile copy changed: volatile copy follows
        if (i_nv_update) begin
          lock_bit <= i_status_one_nonvolatile[`SR1_LOCK_BIT];
          tb_sel   <= i_status_one_nonvolatile[`SR1_TB_BIT];
          bp_field <= i_status_one_nonvolatile[`SR1_BP_HI:`SR1_BP_LO];
        end
        // operation completion
        // a failure keeps the latch and holds busy
        if (busy_op & i_op_done) begin
          busy_op  <= 1'b0;
          cur_kind <= `OPK_NONE;
          if (i_op_error)
            err_hold <= 1'b1;
          else
            write_enable_latch <= 1'b0;
        end
        // command judged at decode, before any state moves
        if (i_cmd_valid) begin
          if (!allow) begin
            o_cmd_ignored <= 1'b1;
          end else begin
            o_cmd_accept <= 1'b1;
            reset_armed  <= (i_cmd_opcode == `OP_RESET_ENABLE);
            // status read: snapshot taken as the opcode arrives
            if (i_cmd_opcode == `OP_READ_SR1) begin
              o_read_data  <= sr1_now;
              o_read_valid <= 1'b1;
            end else if (op_is_wen) begin
              write_enable_latch <= 1'b1;
            end else if (op_is_wdis) begin
              write_enable_latch <= 1'b0;
            end else if (op_is_clr) begin
              // clear status drops the latch and the held failure
              write_enable_latch      <= 1'b0;
              err_hold <= 1'b0;
            end else if (suspend_ok) begin
              o_suspend <= 1'b1;
            end else if (i_cmd_opcode == `OP_RESET) begin
              // reset only counts right after reset enable
              o_soft_reset <= reset_armed;
            end else if (op_is_wrreg) begin
              // register write: latch and busy untouched here
              if (write_enable_latch & ~wr_blocked) begin
                o_reg_write <= 1'b1;
                if (i_wr_targets_prot & ~i_wr_nv) begin
                  lock_bit <= i_wr_data[`SR1_LOCK_BIT];
                  tb_sel   <= i_wr_data[`SR1_TB_BIT];
                  bp_field <= i_wr_data[`SR1_BP_HI:`SR1_BP_LO];
                end
              end else begin
                // refused: latch clear or register set locked
                o_cmd_accept  <= 1'b0;
                o_cmd_ignored <= 1'b1;
              end
            end else if (i_op_start_req) begin
              if (write_enable_latch & ~busy_flag) begin
                o_op_start <= 1'b1;
                busy_op    <= 1'b1;
                cur_kind   <= i_op_kind;
              end else begin
                // refused: latch clear or already busy
                o_cmd_accept  <= 1'b0;
                o_cmd_ignored <= 1'b1;
              end
            end else if (is_read_cmd) begin
              // other reads answer elsewhere, only flagged here
              o_read_valid <= 1'b1;
            end
          end
        end
      end
    end
  end


  // registered status view and protection flag
  // both outputs come straight from flops, one cycle behind
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_status_one_volatile <= `SR1_RESET;
      o_hw_protected        <= 1'b0;
    end else begin
      o_status_one_volatile <= sr1_now;
      o_hw_protected        <= hw_prot;
    end
  end

endmodule // status_protect_enable_busy_logic
`default_nettype wire

// >>> status_protect_enable_busy_logic_sva.sv
`default_nettype none
module spebl_chk (
  // watched ports
  input wire logic       i_core_clk,
  input wire logic       i_rstn,
  input wire logic       i_write_protect_n,
  input wire logic       i_cmd_valid,
  input wire logic [7:0] i_cmd_opcode,
  input wire logic       i_wr_targets_prot,
  input wire logic [7:0] i_status_one_nonvolatile,
  input wire logic [7:0] i_config_one_volatile,
  input wire logic [7:0] i_config_two_volatile,
  input wire logic       i_op_done,
  input wire logic       i_op_error,
  input wire logic [7:0] o_status_one_volatile,
  input wire logic [7:0] o_read_data,
  input wire logic       o_read_valid,
  input wire logic       o_cmd_accept,
  input wire logic       o_cmd_ignored,
  input wire logic       o_op_start,
  input wire logic       o_hw_protected
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  wire [7:0] st;
  // shown status lags the internal copy by one cycle
  assign st = o_status_one_volatile;
  sequence idle_cmd(op);
    i_cmd_valid && i_cmd_opcode == op && !st[0] && !i_op_done;
  endsequence
  sequence wrr_quiet;
    (i_cmd_valid && i_cmd_opcode == 8'h01 && !i_op_done) ##1 !i_op_done;
  endsequence
  chk_wel_set: assert property (idle_cmd(8'h06) |=> o_cmd_accept ##1 st[1])
    else $error("enable latch not set");
  chk_wel_clear: assert property (idle_cmd(8'h04) |=> o_cmd_accept ##1 !st[1])
    else $error("enable latch not cleared");
  chk_wrr_keeps: assert property (wrr_quiet |-> ##1 $stable(st[1:0]))
    else $error("register write moved latch or busy");
  chk_busy_filter: assert property (i_cmd_valid && st[0] && !$past(i_op_done)
    && !$past(i_cmd_valid) && !(i_cmd_opcode inside {8'h05, 8'h07, 8'h65,
    8'h75, 8'h30, 8'h35, 8'h15, 8'h33, 8'h66, 8'h99}) |=> o_cmd_ignored)
    else $error("command taken while busy");
  chk_start_wel: assert property (o_op_start |-> st[1])
    else $error("operation started without latch");
  chk_prot_refuse: assert property (i_cmd_valid && i_cmd_opcode == 8'h01 &&
    i_wr_targets_prot && o_hw_protected && $past(o_hw_protected)
    |=> o_cmd_ignored)
    else $error("protected write not refused");
  chk_pin_release: assert property ((i_write_protect_n ||
    i_config_one_volatile[1] || i_config_two_volatile[3])[*4]
    |-> !o_hw_protected)
    else $error("protection held with pin released");
  chk_done_clear: assert property (i_op_done && !i_op_error && st[0] &&
    !i_cmd_valid && !$past(i_cmd_valid) |-> ##2 !st[1])
    else $error("latch kept after good completion");
  chk_error_hold: assert property (i_op_done && i_op_error ##1 !i_cmd_valid
    |-> ##1 st[0])
    else $error("busy dropped after failure");
  chk_read_match: assert property (o_read_valid &&
    $past(i_cmd_opcode) == 8'h05 |-> o_read_data == st)
    else $error("read data differs from status");
  chk_reset_load: assert property ($rose(i_rstn) |->
    ##2 st == $past(i_status_one_nonvolatile, 2))
    else $error("status not loaded from defaults");
endmodule // spebl_chk
bind status_protect_enable_busy_logic spebl_chk chk_u (.*);
`default_nettype wire

// >>> spi_host_model.sv
`default_nettype none
module spi_host_model (
  // clock
  input  wire logic       i_core_clk,
  // decoded command toward the block
  output var  logic       o_cmd_valid,
  output var  logic [7:0] o_cmd_opcode,
  output var  logic [7:0] o_wr_data,
  output var  logic       o_wr_prot,
  output var  logic       o_op_req,
  output var  logic [2:0] o_op_kind
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    o_cmd_valid = 1'b0;
    {o_cmd_opcode, o_wr_data, o_wr_prot, o_op_req, o_op_kind} = '0;
  end
  // one command cycle; released opcode, data and prot show the inverse filler, the kind is kept
  task automatic send(input logic [7:0] op, d, input logic p,
                      input logic [2:0] k);
    @(posedge i_core_clk);
    o_cmd_valid <= 1'b1;
    {o_cmd_opcode, o_wr_data, o_wr_prot} <= {op, d, p};
    {o_op_req, o_op_kind} <= {k != 3'h0, k};
    @(posedge i_core_clk);
    o_cmd_valid <= 1'b0;
    {o_cmd_opcode, o_wr_data, o_wr_prot} <= ~{op, d, p};
    o_op_req <= 1'b0;
  endtask
endmodule // spi_host_model
`default_nettype wire

// >>> status_protect_enable_busy_logic_tb.sv
`default_nettype none
module status_protect_enable_busy_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rstn, wp_n, nvu, done, err, cv, p, req, rv, acc, ign;
  logic       rw, sus, srst;
  logic [7:0] nv, cf1, op, wd, st, rd;
  logic [2:0] k;
  int         n_mismatch, check_count;
  spi_host_model host_u (.i_core_clk(clk), .o_cmd_valid(cv),
    .o_cmd_opcode(op), .o_wr_data(wd), .o_wr_prot(p), .o_op_req(req),
    .o_op_kind(k));
  status_protect_enable_busy_logic dut_u (.i_core_clk(clk), .i_rstn(rstn),
    .i_write_protect_n(wp_n), .i_cmd_valid(cv), .i_cmd_opcode(op),
    .i_wr_data(wd), .i_wr_targets_prot(p), .i_wr_nv(1'b0),
    .i_soft_reset_done(1'b0), .i_status_one_nonvolatile(nv),
    .i_nv_update(nvu), .i_config_one_volatile(cf1),
    .i_config_two_volatile(8'h00), .i_op_start_req(req), .i_op_kind(k),
    .i_op_done(done), .i_op_error(err), .o_status_one_volatile(st),
    .o_read_data(rd), .o_read_valid(rv), .o_cmd_accept(acc),
    .o_cmd_ignored(ign), .o_op_start(), .o_reg_write(rw),
    .o_suspend(sus), .o_soft_reset(srst), .o_hw_protected());
  task automatic chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // send one command, look at accept and ignored in the answer cycle
  task automatic cmd(input logic [7:0] o, d, input logic pr,
                     input logic [2:0] kd, input logic ok);
    host_u.send(o, d, pr, kd);
    #1;
    chk({6'h00, acc, ign}, ok ? 8'h02 : 8'h01);
  endtask
  task automatic rd_st(input logic [7:0] exp);
    cmd(8'h05, 8'h00, 1'b0, 3'h0, 1'b1);
    chk({7'h00, rv}, 8'h01);
    chk(rd, exp);
  endtask
  task automatic finish_op(input logic e);
    @(posedge clk);
    {done, err} <= {1'b1, e};
    @(posedge clk);
    {done, err} <= 2'b00;
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {rstn, wp_n, nvu, done, err} = 5'b00000;
    {nv, cf1} = {8'hc2, 8'h00};
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd_st(8'hc2);
    cmd(8'h01, 8'h3d, 1'b1, 3'h0, 1'b0);
    cmd(8'h01, 8'h3d, 1'b0, 3'h0, 1'b1);
    @(posedge clk);
    cf1 <= 8'h02;
    repeat (4) @(posedge clk);
    cmd(8'h01, 8'h3d, 1'b1, 3'h0, 1'b1);
    chk({7'h00, rw}, 8'h01);
    rd_st(8'h3e);
    cmd(8'h04, 8'h00, 1'b0, 3'h0, 1'b1);
    rd_st(8'h3c);
    cmd(8'h02, 8'h00, 1'b0, 3'h1, 1'b0);
    cmd(8'h06, 8'h00, 1'b0, 3'h0, 1'b1);
    cmd(8'h02, 8'h00, 1'b0, 3'h1, 1'b1);
    rd_st(8'h3f);
    cmd(8'h06, 8'h00, 1'b0, 3'h0, 1'b0);
    cmd(8'h35, 8'h00, 1'b0, 3'h0, 1'b1);
    cmd(8'h75, 8'h00, 1'b0, 3'h0, 1'b1);
    chk({7'h00, sus}, 8'h01);
    finish_op(1'b0);
    rd_st(8'h3c);
    cmd(8'h75, 8'h00, 1'b0, 3'h0, 1'b0);
    cmd(8'h50, 8'h00, 1'b0, 3'h0, 1'b1);
    cmd(8'h02, 8'h00, 1'b0, 3'h2, 1'b1);
    finish_op(1'b1);
    rd_st(8'h3f);
    cmd(8'h06, 8'h00, 1'b0, 3'h0, 1'b0);
    cmd(8'h30, 8'h00, 1'b0, 3'h0, 1'b1);
    rd_st(8'h3c);
    @(posedge clk);
    {nv, nvu} <= {8'h40, 1'b1};
    @(posedge clk);
    nvu <= 1'b0;
    rd_st(8'h40);
    cmd(8'h66, 8'h00, 1'b0, 3'h0, 1'b1);
    cmd(8'h99, 8'h00, 1'b0, 3'h0, 1'b1);
    chk({7'h00, srst}, 8'h01);
    report_and_stop();
  end
endmodule // status_protect_enable_busy_logic_tb
`default_nettype wire
